// ### src/csr_dev.sv
// converter end: serial decode, conversion sequencing, result read-back
// assumes the host keeps the link timing of csr_host; sample_in is steady at conversion end
// Behaviour
// - start by start byte or request bit
// - serial start on second divided-clock fall
// - busy rises one divided period later
// - busy falls at conversion end
// - request during conversion is queued
// - one-entry queue, newer request overwrites
// - queued conversion starts with no gap
// - convert pin starts on second clock fall
// - host holds convert two clocks each level
// - convert pin aborts and restarts conversion
// - two-bit field in reg 3 selects read-back
// - only serial starts arm automatic read-back
// - first bit active edge, rest inactive edge
// - manual reads: addr 1 MSB, addr 0 LSB
// - read returns latest completed result
// - mode 1 acts as 16-bit read addr 1
// - auto read-back shows latest completed result
// - mode 2 acts as 16-bit read addr 0
// - mode 3 keeps full conversion length
// - unused addresses read as zero
// - host writes zero to unused bits
// - host avoids completion inside a byte
// - host waits busy low, chip select low
// - mode 3 acts as 8-bit read addr 1
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module csr_dev #(
  parameter int CONVERSION_CLOCK_DIV = csr_pkg::CSR_CONVERSION_CLOCK_DIV,
  parameter int CONV_DIVIDED_CONVERSION_CLOCK = csr_pkg::CSR_CONV_DIVIDED_CONVERSION_CLOCK
) (
  input wire logic ref_clk,                         // clock
  input wire logic rst_n,                           // async reset, active low
  csr_link_if.dev link,                             // serial link
  input wire logic [csr_pkg::CSR_RES_W-1:0] sample_in, // value taken at conversion end
  output logic [csr_pkg::CSR_RES_W-1:0] result,     // latest completed result
  output logic conv_start,                          // pulse, conversion begins
  output logic conv_done                            // pulse, conversion completes
);
  import csr_pkg::*;

  if (CONVERSION_CLOCK_DIV < 2 || CONV_DIVIDED_CONVERSION_CLOCK < 2) begin : g_bad_param
    $error("csr_dev: bad parameter");
  end

  typedef enum logic [2:0] {PH_INSTR = 3'b001, PH_WDATA = 3'b010, PH_RDATA = 3'b100} csr_ph_t;

  logic s_sclk, s_cs_n, s_din, s_conv, sclk_q, conv_q, act, inact;
  csr_sync #(.W(4)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({link.sclk, link.cs_n, link.din, link.convert}),
    .rst_val(4'h4),
    .q({s_sclk, s_cs_n, s_din, s_conv})
  );
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      conv_q <= 1'b0;
    end else begin
      sclk_q <= s_sclk;
      conv_q <= s_conv;
    end
  end
  assign act = s_sclk & ~sclk_q & ~s_cs_n;
  assign inact = ~s_sclk & sclk_q & ~s_cs_n;

  // ---------------- serial interface ----------------
  csr_ph_t ph;
  logic [2:0] bit_cnt;
  logic [6:0] shreg;
  logic [7:0] tx, rx_byte, out_byte;
  logic [4:0] rd_addr, wr_addr;
  logic rd_two, rd_idx, serial_req, dout_r;
  logic [3:0] ctrl;
  csr_rb_t rb;
  logic [1:0] div_sel;

  assign rx_byte = {shreg, s_din};
  assign rb = csr_rb_t'(ctrl[CSR_RB_LSB +: 2]);
  assign div_sel = ctrl[CSR_DIV_LSB +: 2];

  // byte presented from the addressed register at the first active edge of each byte
  always_comb begin
    out_byte = 8'h00;
    unique case (rd_addr)
      CSR_A_RES_HI: out_byte = rd_idx ? result[7:0] : result[15:8];
      CSR_A_RES_LO: out_byte = rd_idx ? result[15:8] : result[7:0];
      CSR_A_CTRL: out_byte = {4'h0, ctrl};
      default: out_byte = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= PH_INSTR;
      bit_cnt <= 3'h0;
      shreg <= 7'h00;
      tx <= 8'h00;
      rd_addr <= 5'h00;
      wr_addr <= 5'h00;
      rd_two <= 1'b0;
      rd_idx <= 1'b0;
      serial_req <= 1'b0;
      ctrl <= CSR_CTRL_RST;
      dout_r <= 1'b0;
    end else begin
      serial_req <= 1'b0;
      if (s_cs_n) begin
        ph <= PH_INSTR;
        bit_cnt <= 3'h0;
      end else if (act) begin
        shreg <= rx_byte[6:0];
        bit_cnt <= bit_cnt + 3'h1;
        if (ph == PH_RDATA && bit_cnt == 3'h0) begin
          tx <= out_byte;
          dout_r <= out_byte[7];
        end
        if (bit_cnt == 3'h7) begin
          unique case (ph)
            PH_INSTR: begin
              if (rx_byte[CSR_I_START]) begin
                serial_req <= 1'b1;
                ph <= PH_INSTR;
              end else if (rx_byte[CSR_I_READ]) begin
                ph <= PH_RDATA;
                rd_addr <= rx_byte[CSR_ADDR_W-1:0];
                rd_two <= rx_byte[CSR_I_WIDE];
                rd_idx <= 1'b0;
              end else begin
                ph <= PH_WDATA;
                wr_addr <= rx_byte[CSR_ADDR_W-1:0];
              end
            end
            PH_WDATA: begin
              ph <= PH_INSTR;
              if (wr_addr == CSR_A_CTRL) ctrl <= rx_byte[3:0];
              if ((wr_addr == CSR_A_REQ0 || wr_addr == CSR_A_REQ1) && rx_byte[CSR_REQ_BIT]) begin
                serial_req <= 1'b1;
              end
            end
            PH_RDATA: begin
              rd_idx <= 1'b1;
              if (!rd_two || rd_idx) ph <= PH_INSTR;
            end
            default: ph <= PH_INSTR;
          endcase
        end
      end else if (inact && ph == PH_RDATA && bit_cnt != 3'h0) begin
        dout_r <= tx[3'h7 - bit_cnt];
      end
      // automatic read-back, armed only by serial starts
      if (serial_req && !s_cs_n && rb != CSR_RB_MANUAL) begin
        ph <= PH_RDATA;
        rd_idx <= 1'b0;
        bit_cnt <= 3'h0;
        rd_addr <= (rb == CSR_RB_LSB_FIRST) ? CSR_A_RES_LO : CSR_A_RES_HI;
        rd_two <= (rb != CSR_RB_MSB_ONLY);
      end
    end
  end
  assign link.dout = dout_r;

  // ---------------- conversion sequencing ----------------
  logic [$clog2(CONVERSION_CLOCK_DIV)-1:0] ccnt;
  logic [2:0] dcnt, dmask;
  logic conversion_clock_fall, divided_conversion_clock_fall, run, pending, finish, busy_r;
  logic [1:0] ser_wait, pin_wait;
  logic [$clog2(CONV_DIVIDED_CONVERSION_CLOCK)-1:0] dper;

  assign conversion_clock_fall = (ccnt == ($clog2(CONVERSION_CLOCK_DIV))'(CONVERSION_CLOCK_DIV - 1));
  always_comb begin
    unique case (div_sel)
      2'h0: dmask = 3'h0;
      2'h1: dmask = 3'h1;
      2'h2: dmask = 3'h3;
      2'h3: dmask = 3'h7;
    endcase
  end
  assign divided_conversion_clock_fall = conversion_clock_fall && ((dcnt & dmask) == dmask);
  assign finish = run && divided_conversion_clock_fall && dper == ($clog2(CONV_DIVIDED_CONVERSION_CLOCK))'(CONV_DIVIDED_CONVERSION_CLOCK - 1);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ccnt <= '0;
    end else begin
      ccnt <= conversion_clock_fall ? '0 : ccnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dcnt <= 3'h0;
      run <= 1'b0;
      dper <= '0;
      pending <= 1'b0;
      ser_wait <= 2'h0;
      pin_wait <= 2'h0;
      busy_r <= 1'b0;
      conv_start <= 1'b0;
      conv_done <= 1'b0;
      result <= '0;
    end else begin
      conv_start <= 1'b0;
      conv_done <= 1'b0;
      if (conversion_clock_fall) dcnt <= dcnt + 3'h1;
      if (s_conv && !conv_q) pin_wait <= 2'h2;
      else if (conversion_clock_fall && pin_wait != 2'h0) pin_wait <= pin_wait - 2'h1;
      if (serial_req) begin
        if (run && !finish) pending <= 1'b1;
        else ser_wait <= 2'h2;
      end else if (divided_conversion_clock_fall && ser_wait != 2'h0) begin
        ser_wait <= ser_wait - 2'h1;
      end
      if (run && divided_conversion_clock_fall) begin
        dper <= dper + 1'b1;
        busy_r <= 1'b1;
      end
      if (finish) begin
        busy_r <= 1'b0;
        result <= sample_in;
        conv_done <= 1'b1;
        dper <= '0;
        if (pending) begin
          pending <= 1'b0;
          conv_start <= 1'b1;
        end else begin
          run <= 1'b0;
        end
      end
      if (divided_conversion_clock_fall && ser_wait == 2'h1) begin
        if (run && !finish) begin
          pending <= 1'b1;
        end else begin
          run <= 1'b1;
          dper <= '0;
          busy_r <= 1'b0;
          conv_start <= 1'b1;
        end
      end
      if (conversion_clock_fall && pin_wait == 2'h1) begin
        run <= 1'b1;
        dper <= '0;
        busy_r <= 1'b0;
        dcnt <= 3'h0;
        conv_start <= 1'b1;
      end
    end
  end
  assign link.busy = busy_r;
endmodule : csr_dev
`default_nettype wire

// ### src/csr_pkg.sv
// shared constants of the conversion start / read-back link
// assumes both ends and the bench import it
package csr_pkg;
  localparam int CSR_CONVERSION_CLOCK_DIV = 2;          // ref_clk cycles per conversion clock
  localparam int CSR_CONV_DIVIDED_CONVERSION_CLOCK = 16;        // divided periods per conversion
  localparam int CSR_SCLK_HALF = 8;         // ref_clk cycles per half serial clock
  localparam int CSR_SYNC_LAT = 3;          // pin sampling delay, ref_clk cycles
  localparam int CSR_CONV_HOLD_CONVERSION_CLOCK = 2;    // least convert pin high or low time
  localparam int CSR_RES_W = 16;
  // instruction byte
  localparam int CSR_I_START = 7;           // direct start byte
  localparam int CSR_I_READ = 6;
  localparam int CSR_I_WIDE = 5;
  localparam int CSR_ADDR_W = 5;
  // device registers
  localparam logic [4:0] CSR_A_RES_LO = 5'h00;
  localparam logic [4:0] CSR_A_RES_HI = 5'h01;
  localparam logic [4:0] CSR_A_CTRL = 5'h03;
  localparam logic [4:0] CSR_A_REQ0 = 5'h04;
  localparam logic [4:0] CSR_A_REQ1 = 5'h05;
  localparam int CSR_REQ_BIT = 7;           // conversion_request_bit in regs 4 and 5
  localparam int CSR_RB_LSB = 0;            // readback_select_hi/lo at [1:0]
  localparam int CSR_DIV_LSB = 2;           // clock_divider_select_hi/lo at [3:2]
  localparam logic [3:0] CSR_CTRL_RST = 4'h0;
  typedef enum logic [1:0] {
    CSR_RB_MANUAL = 2'h0, CSR_RB_MSB_FIRST = 2'h1, CSR_RB_LSB_FIRST = 2'h2, CSR_RB_MSB_ONLY = 2'h3
  } csr_rb_t;
  // host Avalon registers (byte addresses)
  localparam logic [3:0] CSR_H_CMD = 4'h0;
  localparam logic [3:0] CSR_H_STAT = 4'h4;
  localparam logic [3:0] CSR_H_RES = 4'h8;
  localparam int CSR_C_INSTR_LSB = 0;       // [7:0] instruction byte
  localparam int CSR_C_SEND = 8;            // send the instruction byte
  localparam int CSR_C_WR = 9;              // send one data byte
  localparam int CSR_C_NRD_LSB = 10;        // [11:10] bytes to read
  localparam int CSR_C_WAITB = 12;          // wait for busy to fall before reading
  localparam int CSR_C_CONV = 13;           // pulse the convert pin
  localparam int CSR_C_WDATA_LSB = 16;      // [23:16] data byte
endpackage : csr_pkg

// ### src/csr_link_if.sv
// serial link between the converter and its host
// assumes both ends run on the same ref_clk; each samples the other's pins
`timescale 1ns/10ps
`default_nettype none
interface csr_link_if;
  logic sclk;     // serial clock, host driven, active edge rising
  logic cs_n;     // chip select, active low
  logic din;      // host to device data
  logic dout;     // device to host data
  logic convert;  // convert pin, rising edge starts
  logic busy;     // conversion running
  modport dev (input sclk, cs_n, din, convert, output dout, busy);
  modport host (output sclk, cs_n, din, convert, input dout, busy);
endinterface : csr_link_if
`default_nettype wire

// ### src/csr_sync.sv
// two-stage synchroniser for pin inputs
// assumes inputs are asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module csr_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,        // clock
  input wire logic rst_n,          // async reset
  input wire logic [W-1:0] d,      // pin levels
  input wire logic [W-1:0] rst_val, // level assumed during reset (constant)
  output logic [W-1:0] q           // synchronised levels
);
  // both stages hold the level relative to rst_val, so q shows rst_val in reset
  logic [W-1:0] meta, hold;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      hold <= '0;
    end else begin
      meta <= d ^ rst_val;
      hold <= meta;
    end
  end
  assign q = hold ^ rst_val;
endmodule : csr_sync
`default_nettype wire

// ### src/csr_host.sv
// host end: runs one serial transaction or one convert pin pulse per command written over Avalon-MM
// assumes csr_dev on the far side with the same ref_clk rate
`timescale 1ns/10ps
`default_nettype none
module csr_host #(
  parameter int SCLK_HALF = csr_pkg::CSR_SCLK_HALF,
  parameter int CONVERSION_CLOCK_DIV = csr_pkg::CSR_CONVERSION_CLOCK_DIV
) (
  input wire logic ref_clk,             // clock
  input wire logic rst_n,               // async reset, active low
  csr_link_if.host link,                // serial link
  input wire logic [3:0] avs_address,   // byte address
  input wire logic avs_read,            // read request
  input wire logic avs_write,           // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata,     // read data
  output logic avs_waitrequest          // stall
);
  import csr_pkg::*;

  localparam int HOLD_CYC = CSR_CONV_HOLD_CONVERSION_CLOCK * CONVERSION_CLOCK_DIV + CSR_SYNC_LAT;
  localparam int CW = $clog2(HOLD_CYC + SCLK_HALF + 1);

  if (SCLK_HALF < 2 * CSR_SYNC_LAT) begin : g_bad_param
    $error("csr_host: SCLK_HALF too small");
  end

  typedef enum logic [7:0] {
    H_IDLE = 8'h01, H_INSTR = 8'h02, H_WDAT = 8'h04, H_WAITB = 8'h08,
    H_RDAT = 8'h10, H_CVHI = 8'h20, H_CVLO = 8'h40, H_FIN = 8'h80
  } csr_hst_t;

  logic s_dout, s_busy;
  csr_sync #(.W(2)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({link.dout, link.busy}),
    .rst_val(2'h0),
    .q({s_dout, s_busy})
  );

  csr_hst_t st;
  logic [CW-1:0] hc;
  logic [2:0] bi;
  logic [7:0] txs, rx, wdata;
  logic [1:0] nrd;
  logic wr_pend, waitb, bseen, sclk_r, cs_n_r, din_r, conv_r, res_new, rd_ack;
  logic [15:0] res;
  logic tick, cmd_take, res_rd, byte_end;
  csr_hst_t after_tx;

  assign cmd_take = avs_write && avs_address == CSR_H_CMD && st == H_IDLE;
  assign res_rd = avs_read && !rd_ack && avs_address == CSR_H_RES;
  assign avs_waitrequest = (avs_read && !rd_ack) || (avs_write && avs_address == CSR_H_CMD
                           && st != H_IDLE);
  assign tick = (hc == CW'(SCLK_HALF - 1));
  assign byte_end = tick && sclk_r && bi == 3'h7;
  // phase after a transmitted byte
  assign after_tx = wr_pend ? H_WDAT : waitb ? H_WAITB : (nrd != 2'h0) ? H_RDAT : H_FIN;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= H_IDLE;
      hc <= '0;
      bi <= 3'h0;
      txs <= 8'h00;
      rx <= 8'h00;
      wdata <= 8'h00;
      nrd <= 2'h0;
      wr_pend <= 1'b0;
      waitb <= 1'b0;
      bseen <= 1'b0;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      din_r <= 1'b0;
      conv_r <= 1'b0;
      res <= 16'h0000;
    end else begin
      hc <= tick ? '0 : hc + 1'b1;
      unique case (st)
        H_IDLE: begin
          hc <= '0;
          if (cmd_take) begin
            wdata <= avs_writedata[CSR_C_WDATA_LSB +: 8];
            wr_pend <= avs_writedata[CSR_C_WR];
            waitb <= avs_writedata[CSR_C_WAITB];
            nrd <= avs_writedata[CSR_C_NRD_LSB +: 2];
            bseen <= 1'b0;
            bi <= 3'h0;
            if (avs_writedata[CSR_C_CONV]) begin
              st <= H_CVHI;
              conv_r <= 1'b1;
            end else begin
              cs_n_r <= 1'b0;
              if (avs_writedata[CSR_C_SEND]) begin
                st <= H_INSTR;
                txs <= avs_writedata[CSR_C_INSTR_LSB +: 8];
                din_r <= avs_writedata[CSR_C_INSTR_LSB + 7];
              end else if (avs_writedata[CSR_C_WAITB]) begin
                st <= H_WAITB;
              end else begin
                st <= H_RDAT;
              end
            end
          end
        end
        H_INSTR, H_WDAT, H_RDAT: begin
          if (tick) begin
            sclk_r <= ~sclk_r;
            if (sclk_r) begin
              rx <= {rx[6:0], s_dout};
              bi <= bi + 3'h1;
              txs <= {txs[6:0], 1'b0};
              din_r <= txs[6];
            end
          end
          if (byte_end) begin
            if (st == H_RDAT) begin
              res <= {res[7:0], rx[6:0], s_dout};
              nrd <= nrd - 2'h1;
              if (nrd == 2'h1) st <= H_FIN;
            end else if (st == H_WDAT) begin
              wr_pend <= 1'b0;
              st <= waitb ? H_WAITB : (nrd != 2'h0) ? H_RDAT : H_FIN;
            end else begin
              st <= after_tx;
              if (wr_pend) begin
                txs <= wdata;
                din_r <= wdata[7];
              end
            end
          end
        end
        H_WAITB: begin
          hc <= '0;
          if (s_busy) bseen <= 1'b1;
          if (bseen && !s_busy) st <= (nrd != 2'h0) ? H_RDAT : H_FIN;
        end
        H_CVHI: begin
          hc <= hc + 1'b1;
          if (hc == CW'(HOLD_CYC - 1)) begin
            hc <= '0;
            conv_r <= 1'b0;
            st <= H_CVLO;
          end
        end
        H_CVLO: begin
          hc <= hc + 1'b1;
          if (hc == CW'(HOLD_CYC - 1)) st <= H_IDLE;
        end
        H_FIN: begin
          din_r <= 1'b0;
          if (tick) begin
            cs_n_r <= 1'b1;
            st <= H_IDLE;
          end
        end
      endcase
    end
  end

  // result-ready flag: a new result wins over a read that clears it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_new <= 1'b0;
    end else if (st == H_RDAT && byte_end && nrd == 2'h1) begin
      res_new <= 1'b1;
    end else if (res_rd) begin
      res_new <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_ack <= avs_read && !rd_ack;
      if (avs_read && !rd_ack) begin
        unique case (avs_address)
          CSR_H_STAT: avs_readdata <= {29'h0, res_new, s_busy, st != H_IDLE};
          CSR_H_RES: avs_readdata <= {16'h0000, res};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign link.sclk = sclk_r;
  assign link.cs_n = cs_n_r;
  assign link.din = din_r;
  assign link.convert = conv_r;
endmodule : csr_host
`default_nettype wire

// ### test/csr_chk.sv
// concurrent checks on the convert pin, busy and the conversion pulses
// assumes one ref_clk domain; instantiated beside the link interface
`timescale 1ns/10ps
`default_nettype none
module csr_chk #(
  parameter int CONVERSION_CLOCK_DIV = 2,
  parameter int CONV_DIVIDED_CONVERSION_CLOCK = 16
) (
  input wire logic ref_clk,    // clock
  input wire logic rst_n,      // async reset, active low
  input wire logic convert,    // convert pin
  input wire logic busy,       // conversion running
  input wire logic conv_start, // conversion begins
  input wire logic conv_done   // conversion completes
);
  logic [15:0] since;

  // cycles since the last conversion start, saturating
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      since <= 16'hFFFF;
    end else if (conv_start) begin
      since <= 16'h0001;
    end else if (since != 16'hFFFF) begin
      since <= since + 16'h0001;
    end
  end

  // true when n is mul divided periods for one of the four divider settings
  function automatic logic per_ok(input logic [15:0] n, input int mul);
    per_ok = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (n == 16'(mul * (CONVERSION_CLOCK_DIV << k))) per_ok = 1'b1;
    end
  endfunction : per_ok

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_high_hold;
    convert [*4];
  endsequence
  sequence s_low_hold;
    !convert [*4];
  endsequence

  a_busy_low_first: assert property (conv_start |=> !busy)
    else $error("busy high in first divided period");
  a_busy_rise_time: assert property ($rose(busy) |-> per_ok(since, 1))
    else $error("busy rose at wrong delay after start");
  a_conv_length: assert property (conv_done |-> per_ok(since, CONV_DIVIDED_CONVERSION_CLOCK))
    else $error("conversion length wrong");
  a_busy_fall_cause: assert property ($fell(busy) |->
    (conv_done || $past(conv_done)) or ##[0:12] conv_start)
    else $error("busy fell without completion or restart");
  a_busy_ends: assert property (conv_done |-> !busy)
    else $error("busy still high at completion");
  a_start_from_pin: assert property ($rose(convert) |-> ##[3:12] conv_start)
    else $error("convert pin did not start a conversion");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  a_convert_high: assert property ($rose(convert) |-> s_high_hold)
    else $error("convert high too short");
  a_convert_low: assert property ($fell(convert) |-> s_low_hold)
    else $error("convert low too short");
endmodule : csr_chk
`default_nettype wire

// ### test/conversion_start_readback_ctrl_test.sv
// self-checking bench: host and converter ends joined by the link
// assumes the csr_pkg constants; the host is driven over Avalon-MM
`timescale 1ns/10ps
`default_nettype none
module conversion_start_readback_ctrl_test;
  import csr_pkg::*;
  localparam int CONV_N = 32; // longer conversion so requests can queue
  logic ref_clk;
  logic rst_n;
  logic [15:0] sample_in;
  logic [15:0] result;
  logic conv_start;
  logic conv_done;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] rd;
  logic [15:0] exp_res;
  logic sclk_q = 1'b0;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int last_rise = 0;
  int start_cyc = 0;
  int done_cyc = 0;
  int n_start = 0;
  int n_done = 0;

  csr_link_if link_if();
  csr_dev #(.CONVERSION_CLOCK_DIV(CSR_CONVERSION_CLOCK_DIV), .CONV_DIVIDED_CONVERSION_CLOCK(CONV_N)) csr_dev_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .link(link_if.dev), .sample_in(sample_in), .result(result),
    .conv_start(conv_start), .conv_done(conv_done));
  csr_host csr_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link_if.host),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  csr_chk #(.CONVERSION_CLOCK_DIV(CSR_CONVERSION_CLOCK_DIV), .CONV_DIVIDED_CONVERSION_CLOCK(CONV_N)) csr_chk_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .convert(link_if.convert), .busy(link_if.busy),
    .conv_start(conv_start), .conv_done(conv_done));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // cycle stamps of serial clock rises and conversion pulses
  always @(posedge ref_clk) begin
    cyc++;
    if (link_if.sclk === 1'b1 && sclk_q === 1'b0) last_rise = cyc;
    sclk_q = link_if.sclk;
    if (conv_start === 1'b1) begin
      n_start++;
      start_cyc = cyc;
    end
    if (conv_done === 1'b1) begin
      n_done++;
      done_cyc = cyc;
    end
  end

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_rng(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("CHECK FAILED t=%0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng

  task automatic av_go(input logic wr, input logic [3:0] a, input logic [31:0] d);
    logic ok;
    int n;
    ok = 1'b0;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
      ok = (avs_waitrequest === 1'b0);
      n++;
    end while (!ok && n < 5000);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (!ok) chk_rng(n, 0, 0);
  endtask : av_go

  function automatic logic [31:0] mk(input logic [7:0] ins, input logic wr,
      input logic [7:0] wd, input logic [1:0] nrd, input logic wb);
    mk = {8'h00, wd, 2'b00, 1'b0, wb, nrd, wr, 1'b1, ins};
  endfunction : mk

  task automatic cmd(input logic [31:0] c);
    av_go(1'b1, CSR_H_CMD, c);
    rd = 32'h1;
    for (int i = 0; i < 1000 && rd[0] !== 1'b0; i++)
      av_go(1'b0, CSR_H_STAT, 32'h0);
    if (rd[0] !== 1'b0) chk_rng(1, 0, 0);
  endtask : cmd

  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    cmd(mk({3'b000, a}, 1'b1, d, 2'd0, 1'b0));
  endtask : wreg

  task automatic wait_n(input bit dn, input int k);
    for (int i = 0; i < 3000 && (dn ? n_done : n_start) < k; i++)
      @(posedge ref_clk);
    chk_rng(dn ? n_done : n_start, k, k);
  endtask : wait_n

  task automatic t_direct();
    sample_in <= 16'hA51C;
    cmd(mk(8'h80, 1'b0, 8'h00, 2'd0, 1'b0));
    wait_n(0, 1);
    chk_rng(start_cyc - last_rise, CSR_SYNC_LAT + 2, CSR_SYNC_LAT + 4 * CSR_CONVERSION_CLOCK_DIV + 2);
    wait_n(1, 1);
    chk_val(result, 16'hA51C);
    exp_res = 16'hA51C;
  endtask : t_direct

  task automatic t_queue();
    wreg(CSR_A_CTRL, 8'h0C);
    sample_in <= 16'h3C5A;
    wreg(CSR_A_REQ0, 8'h80);
    wait_n(0, 2);
    cmd(mk(8'h80, 1'b0, 8'h00, 2'd0, 1'b0));
    wreg(CSR_A_REQ1, 8'h80);
    wait_n(1, 2);
    wait_n(0, 3);
    chk_rng(start_cyc - done_cyc, 0, 1);
    wait_n(1, 3);
    repeat (4) @(posedge ref_clk);
    chk_rng(n_start, 3, 3);
    chk_val(result, 16'h3C5A);
    exp_res = 16'h3C5A;
  endtask : t_queue

  task automatic t_convert();
    sample_in <= 16'h0F0F;
    wreg(CSR_A_REQ0, 8'h80);
    wait_n(0, 4);
    cmd(32'h0000_2000);
    wait_n(0, 5);
    wait_n(1, 4);
    repeat (8) @(posedge ref_clk);
    chk_rng(n_done, 4, 4);
    chk_rng(done_cyc - start_cyc, CONV_N * 8 * CSR_CONVERSION_CLOCK_DIV, CONV_N * 8 * CSR_CONVERSION_CLOCK_DIV);
    exp_res = 16'h0F0F;
  endtask : t_convert

  task automatic t_readback();
    logic [15:0] v;
    logic [15:0] src;
    logic [1:0] md;
    for (int i = 0; i < 4; i++) begin
      md = (i == 3) ? 2'd1 : 2'(i + 1);
      v = 16'h1357 + 16'(i) * 16'h2222;
      wreg(CSR_A_CTRL, {4'h0, 2'b11, md});
      sample_in <= v;
      cmd(mk(8'h80, 1'b0, 8'h00, (md == 2'd3) ? 2'd1 : 2'd2, i == 3));
      src = (i == 3) ? v : exp_res;
      av_go(1'b0, CSR_H_RES, 32'h0);
      case (md)
        2'd1: chk_val(rd[15:0], src);
        2'd2: chk_val(rd[15:0], {src[7:0], src[15:8]});
        default: chk_val({8'h00, rd[7:0]}, {8'h00, src[15:8]});
      endcase
      wait_n(1, 5 + i);
      exp_res = v;
    end
  endtask : t_readback

  task automatic t_manual();
    logic [7:0] ins;
    logic [15:0] e;
    wreg(CSR_A_CTRL, 8'h0C);
    sample_in <= 16'hBEEF;
    cmd(mk(8'h80, 1'b0, 8'h00, 2'd0, 1'b0));
    for (int i = 0; i < 3; i++) begin
      ins = (i == 0) ? 8'h61 : ((i == 1) ? 8'h60 : 8'h41);
      e = (i == 1) ? {exp_res[7:0], exp_res[15:8]} : exp_res;
      cmd(mk(ins, 1'b0, 8'h00, (i == 2) ? 2'd1 : 2'd2, 1'b0));
      av_go(1'b0, CSR_H_RES, 32'h0);
      if (i == 2) chk_val({8'h00, rd[7:0]}, {8'h00, e[15:8]});
      else chk_val(rd[15:0], e);
      if (i == 0) begin
        wait_n(1, 9);
        exp_res = 16'hBEEF;
      end
    end
  endtask : t_manual

  task automatic results();
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  initial begin
    repeat (40000) @(posedge ref_clk);
    n_fail++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    results();
  end

  initial begin
    rst_n = 1'b0;
    sample_in = 16'h0000;
    exp_res = 16'h0000;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_direct();
    t_queue();
    t_convert();
    t_readback();
    t_manual();
    results();
  end
endmodule : conversion_start_readback_ctrl_test
`default_nettype wire
